/* File: core/pwm_dac_timer.sv */
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/100ps

// Summary of operation
// - counter ticks on divided selected source
// - continuous mode wraps at full width
// - up mode counts zero to period
// - period zero in up mode counts full
// - up-down mode counts up then down
// - period latch copies period compare register
// - up period lasts latch plus one ticks
// - in up mode at latch value next count is zero
// - entering up above latch restarts zero
// - duty compare and mode drive pin
// - duty latch loads only at counter zero when selected
// - reset/set output mode seven supported
// - in up mode with duty below period, duty equals duty plus one over period compare plus one
module pwm_dac_timer
  import pwm_dac_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // classic wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // tick sources
  input  wire logic              ext_tick_pin,
  input  wire logic              aux_tick_pin,
  input  wire logic              subsystem_clock_tick,
  // pwm port pin
  output logic                   pwm_out
);
  import pwm_dac_pkg::*;

  counter_cfg_s       cnt_cfg_ff;
  duty_cfg_s          duty_cfg_ff;
  logic [CNT_W-1:0]   period_compare_ff;
  logic [CNT_W-1:0]   period_latch_ff;
  logic [CNT_W-1:0]   duty_compare_ff;
  logic [CNT_W-1:0]   duty_latch_ff;
  logic [CNT_W-1:0]   cycle_counter_ff;
  logic [CNT_W-1:0]   nxt_cycle_counter;
  count_dir_e         dir_ff;
  count_dir_e         nxt_dir;
  logic [CC_MODE_W-1:0] mode_last_ff;
  logic               pwm_ff;
  logic               ack_ff;
  logic [31:0]        rd_data_ff;
  logic               tick;
  logic               clr_pulse;
  logic               wr_en;
  logic               rd_en;
  logic               run;
  logic [CNT_W-1:0]   up_top;
  logic               up_entry;

  // byte-lane merge of a 16-bit register
  function automatic logic [CNT_W-1:0] merge16(input logic [CNT_W-1:0] old,
                                                input logic [31:0] d,
                                                input logic [3:0] sel);
    logic [CNT_W-1:0] r;
    r = old;
    if (sel[0]) r[7:0] = d[7:0];
    if (sel[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // ---------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------

  // one-wait-state ack, dropped the cycle after it was given;
  // a write lands on the edge at which the master samples ack
  assign wr_en = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign rd_en = wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_data_ff;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
    end
  end

  // read mux, registered; unmapped reads as zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      rd_data_ff <= RD_ZERO;
    end else if (rd_en) begin
      case (wb_adr_i)
        OFS_COUNTER_CONTROL: rd_data_ff <= 32'({cnt_cfg_ff.src, cnt_cfg_ff.div,
                                               cnt_cfg_ff.mode, 4'h0});
        OFS_PERIOD_COMPARE:  rd_data_ff <= 32'(period_compare_ff);
        OFS_DUTY_CONTROL:    rd_data_ff <= 32'({duty_cfg_ff.latch_load_at_zero, 1'b0,
                                               duty_cfg_ff.out_mode, 2'h0,
                                               pwm_ff, 2'h0});
        OFS_DUTY_COMPARE:    rd_data_ff <= 32'(duty_compare_ff);
        default:             rd_data_ff <= RD_ZERO;
      endcase
    end
  end

  // counter_control write; clear bit is a self-clearing pulse
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_cfg_ff <= '0;
    end else if (wr_en && wb_adr_i == OFS_COUNTER_CONTROL && wb_sel_i[1] && wb_sel_i[0]) begin
      cnt_cfg_ff.src  <= wb_dat_i[CC_SRC_LSB +: CC_SRC_W];
      cnt_cfg_ff.div  <= wb_dat_i[CC_DIV_LSB +: CC_DIV_W];
      cnt_cfg_ff.mode <= wb_dat_i[CC_MODE_LSB +: CC_MODE_W];
    end
  end

  assign clr_pulse = wr_en && wb_adr_i == OFS_COUNTER_CONTROL && wb_sel_i[0]
                     && wb_dat_i[CC_CLR_BIT];

  // period compare and duty compare registers; only the selected
  // byte lanes change, the latches pick the value up afterwards
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      period_compare_ff <= CNT_ZERO;
      duty_compare_ff   <= CNT_ZERO;
    end else begin
      if (wr_en && wb_adr_i == OFS_PERIOD_COMPARE) begin
        period_compare_ff <= merge16(period_compare_ff, wb_dat_i, wb_sel_i);
      end
      if (wr_en && wb_adr_i == OFS_DUTY_COMPARE) begin
        duty_compare_ff <= merge16(duty_compare_ff, wb_dat_i, wb_sel_i);
      end
    end
  end

  // duty channel control write; out_bit drives pin in mode 0
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      duty_cfg_ff <= '0;
    end else if (wr_en && wb_adr_i == OFS_DUTY_CONTROL) begin
      if (wb_sel_i[0]) begin
        duty_cfg_ff.out_bit           <= wb_dat_i[DC_OUT_BIT];
        duty_cfg_ff.out_mode[0]       <= wb_dat_i[DC_OMOD_LSB];
        duty_cfg_ff.out_mode[2:1]     <= wb_dat_i[DC_OMOD_LSB+1 +: 2];
      end
      if (wb_sel_i[1]) begin
        duty_cfg_ff.latch_load_at_zero <= wb_dat_i[DC_LLD_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // latches
  // ---------------------------------------------------------------

  // period latch follows the period compare register
  // one cycle behind it on every clock, so a byte-wise write reaches the compare half-written
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      period_latch_ff <= CNT_ZERO;
    end else begin
      period_latch_ff <= period_compare_ff;
    end
  end

  // duty latch: immediate, or only at counter zero when selected
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      duty_latch_ff <= CNT_ZERO;
    end else if (!duty_cfg_ff.latch_load_at_zero) begin
      duty_latch_ff <= duty_compare_ff;
    end else if (cycle_counter_ff == CNT_ZERO) begin
      duty_latch_ff <= duty_compare_ff;
    end
  end

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  assign run = cnt_cfg_ff.mode != MODE_STOP;

  tick_prescaler u_prescaler (
    .sys_clk              (sys_clk),
    .rst_n                (rst_n),
    .clr                  (clr_pulse),
    .run                  (run),
    .src                  (cnt_cfg_ff.src),
    .div                  (cnt_cfg_ff.div),
    .ext_tick_pin         (ext_tick_pin),
    .aux_tick_pin         (aux_tick_pin),
    .subsystem_clock_tick (subsystem_clock_tick),
    .tick                 (tick)
  );

  // zero period in up mode means full range
  assign up_top   = (period_latch_ff == CNT_ZERO) ? CNT_MAX : period_latch_ff;
  assign up_entry = (cnt_cfg_ff.mode == MODE_UP) && (mode_last_ff != MODE_UP);

  // next count and direction per mode
  always_comb begin
    nxt_cycle_counter = cycle_counter_ff;
    nxt_dir           = dir_ff;
    case (cnt_cfg_ff.mode)
      MODE_UP: begin
        if (cycle_counter_ff > up_top) begin
          nxt_cycle_counter = CNT_ZERO;
        end else if (tick) begin
          if (cycle_counter_ff == up_top) begin
            nxt_cycle_counter = CNT_ZERO;
          end else begin
            nxt_cycle_counter = 16'(cycle_counter_ff + CNT_ONE);
          end
        end
      end
      MODE_CONTINUOUS: begin
        if (tick) begin
          nxt_cycle_counter = 16'(cycle_counter_ff + CNT_ONE);
        end
      end
      MODE_UP_DOWN: begin
        if (tick) begin
          if (dir_ff == DIR_UP) begin
            if (cycle_counter_ff >= period_latch_ff) begin
              nxt_dir           = DIR_DOWN;
              nxt_cycle_counter = (cycle_counter_ff == CNT_ZERO) ? CNT_ZERO
                                  : 16'(cycle_counter_ff - CNT_ONE);
            end else begin
              nxt_cycle_counter = 16'(cycle_counter_ff + CNT_ONE);
            end
          end else begin
            if (cycle_counter_ff == CNT_ZERO) begin
              nxt_dir           = DIR_UP;
              nxt_cycle_counter = (period_latch_ff == CNT_ZERO) ? CNT_ZERO : CNT_ONE;
            end else begin
              nxt_cycle_counter = 16'(cycle_counter_ff - CNT_ONE);
            end
          end
        end
      end
      default: begin
        nxt_cycle_counter = cycle_counter_ff;
      end
    endcase
  end

  // counter, direction and mode history
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cycle_counter_ff <= CNT_ZERO;
      dir_ff           <= DIR_UP;
      mode_last_ff     <= MODE_STOP;
    end else begin
      mode_last_ff <= cnt_cfg_ff.mode;
      if (clr_pulse) begin
        cycle_counter_ff <= CNT_ZERO;
        dir_ff           <= DIR_UP;
      end else if (up_entry && cycle_counter_ff > up_top) begin
        cycle_counter_ff <= CNT_ZERO;
      end else begin
        cycle_counter_ff <= nxt_cycle_counter;
        dir_ff           <= nxt_dir;
      end
    end
  end

  // ---------------------------------------------------------------
  // output unit
  // ---------------------------------------------------------------

  // reset/set: low at duty match, high at period; in up mode with duty below period, duty = (duty+1)/(period+1)
  // when duty equals period the low side wins and the pin stays low
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pwm_ff <= 1'b0;
    end else begin
      case (duty_cfg_ff.out_mode)
        OMOD_RESET_SET: begin
          if (tick && run && cycle_counter_ff == duty_latch_ff) begin
            pwm_ff <= 1'b0;
          end else if (tick && run && cycle_counter_ff == period_latch_ff) begin
            pwm_ff <= 1'b1;
          end
        end
        OMOD_OUT_BIT: pwm_ff <= duty_cfg_ff.out_bit;
        default:      pwm_ff <= duty_cfg_ff.out_bit;
      endcase
    end
  end

  assign pwm_out = pwm_ff;

endmodule

/* File: core/pwm_dac_pkg.sv */
package pwm_dac_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 4;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_COUNTER_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_PERIOD_COMPARE  = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_DUTY_CONTROL    = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_DUTY_COMPARE    = 4'hC;

  // ---------------------------------------------------------------
  // counter_control fields
  // ---------------------------------------------------------------
  localparam int unsigned CC_CLR_BIT   = 2;
  localparam int unsigned CC_MODE_LSB  = 4;
  localparam int unsigned CC_DIV_LSB   = 6;
  localparam int unsigned CC_SRC_LSB   = 8;
  localparam int unsigned CC_SRC_W     = 2;
  localparam int unsigned CC_MODE_W    = 2;
  localparam int unsigned CC_DIV_W     = 2;

  // source codes
  localparam logic [CC_SRC_W-1:0] SRC_EXT_TICK  = 2'h0;
  localparam logic [CC_SRC_W-1:0] SRC_AUX_TICK  = 2'h1;
  localparam logic [CC_SRC_W-1:0] SRC_SUBSYSTEM = 2'h2;
  localparam logic [CC_SRC_W-1:0] SRC_SYS_CLK   = 2'h3;

  // counting modes
  localparam logic [CC_MODE_W-1:0] MODE_STOP       = 2'h0;
  localparam logic [CC_MODE_W-1:0] MODE_UP         = 2'h1;
  localparam logic [CC_MODE_W-1:0] MODE_CONTINUOUS = 2'h2;
  localparam logic [CC_MODE_W-1:0] MODE_UP_DOWN    = 2'h3;

  // ---------------------------------------------------------------
  // duty_channel_control fields
  // ---------------------------------------------------------------
  localparam int unsigned DC_OUT_BIT   = 2;
  localparam int unsigned DC_OMOD_LSB  = 5;
  localparam int unsigned DC_OMOD_W    = 3;
  localparam int unsigned DC_LLD_BIT   = 9;

  localparam logic [DC_OMOD_W-1:0] OMOD_OUT_BIT      = 3'h0;
  localparam logic [DC_OMOD_W-1:0] OMOD_RESET_SET    = 3'h7;

  // ---------------------------------------------------------------
  // reset values and constants
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0]  CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE  = 16'h0001;
  localparam logic [CNT_W-1:0]  CNT_MAX  = 16'hFFFF;
  localparam logic [31:0]       RD_ZERO  = 32'h0000_0000;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [CC_SRC_W-1:0]  src;
    logic [CC_DIV_W-1:0]  div;
    logic [CC_MODE_W-1:0] mode;
  } counter_cfg_s;

  typedef struct packed {
    logic                 latch_load_at_zero;
    logic [DC_OMOD_W-1:0] out_mode;
    logic                 out_bit;
  } duty_cfg_s;

  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } count_dir_e;

endpackage

/* File: core/tick_prescaler.sv */
`timescale 1ns/100ps

// ---------------------------------------------------------------
// tick source select and 1/2/4/8 divider
// ---------------------------------------------------------------
module tick_prescaler
  import pwm_dac_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 clr,
  input  wire logic                 run,
  input  wire logic [CC_SRC_W-1:0]  src,
  input  wire logic [CC_DIV_W-1:0]  div,
  input  wire logic                 ext_tick_pin,
  input  wire logic                 aux_tick_pin,
  input  wire logic                 subsystem_clock_tick,
  output logic                      tick
);
  import pwm_dac_pkg::*;

  logic [1:0] ext_sync_ff;
  logic [1:0] aux_sync_ff;
  logic       ext_last_ff;
  logic       aux_last_ff;
  logic       src_tick;
  logic [2:0] div_cnt_ff;
  logic [2:0] div_mask;

  // two-stage synchronisers for pin tick sources
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ext_sync_ff <= 2'h0;
      aux_sync_ff <= 2'h0;
      ext_last_ff <= 1'b0;
      aux_last_ff <= 1'b0;
    end else begin
      ext_sync_ff <= {ext_sync_ff[0], ext_tick_pin};
      aux_sync_ff <= {aux_sync_ff[0], aux_tick_pin};
      ext_last_ff <= ext_sync_ff[1];
      aux_last_ff <= aux_sync_ff[1];
    end
  end

  // pick the raw tick; pin sources count rising edges
  always_comb begin
    case (src)
      SRC_EXT_TICK:  src_tick = ext_sync_ff[1] & ~ext_last_ff;
      SRC_AUX_TICK:  src_tick = aux_sync_ff[1] & ~aux_last_ff;
      SRC_SUBSYSTEM: src_tick = subsystem_clock_tick;
      default:       src_tick = 1'b1;
    endcase
  end

  // divide mask: 0,1,3,7 for /1,/2,/4,/8
  assign div_mask = 3'((4'h1 << div) - 4'h1);

  // divider counter, cleared with the main counter
  always_ff @(posedge sys_clk) begin
    if (!rst_n || clr || !run) begin
      div_cnt_ff <= 3'h0;
    end else if (src_tick) begin
      div_cnt_ff <= (div_cnt_ff == div_mask) ? 3'h0 : 3'(div_cnt_ff + 3'h1);
    end
  end

  assign tick = run & src_tick & (div_cnt_ff == div_mask);

endmodule

/* File: sim/pwm_dac_timer_assertions.sv */
`timescale 1ns/100ps

// ---------------------------------------------------------------
// port checks of the pwm timer
// ---------------------------------------------------------------
module pwm_dac_timer_assert (
  input wire logic                            sys_clk,
  input wire logic                            rst_n,
  input wire logic                            wb_cyc_i,
  input wire logic                            wb_stb_i,
  input wire logic                            wb_we_i,
  input wire logic [pwm_dac_pkg::ADDR_W-1:0]  wb_adr_i,
  input wire logic [3:0]                      wb_sel_i,
  input wire logic [31:0]                     wb_dat_i,
  input wire logic [31:0]                     wb_dat_o,
  input wire logic                            wb_ack_o,
  input wire logic                            ext_tick_pin,
  input wire logic                            aux_tick_pin,
  input wire logic                            subsystem_clock_tick,
  input wire logic                            pwm_out
);
  import pwm_dac_pkg::*;

  logic [9:0]  ctl_ff;
  logic [15:0] per_ff;
  logic [15:0] duty_ff;
  logic [1:0]  rises_ff;
  logic [16:0] gap_ff;
  logic        wr;
  logic        sys_up;

  // completed writes and steady sys_clk up-mode config
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign sys_up = rises_ff == 2'h2 && ctl_ff[9:8] == SRC_SYS_CLK && ctl_ff[5:4] == MODE_UP;

  // snoop of config writes and spacing of pin edges
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctl_ff <= '0;
      per_ff <= '0;
      duty_ff <= '0;
      rises_ff <= '0;
      gap_ff <= '0;
    end else begin
      gap_ff <= $rose(pwm_out) ? 17'h0_0001 : gap_ff + 17'h0_0001;
      if (wr) begin
        rises_ff <= 2'h0;
        if (wb_adr_i == OFS_COUNTER_CONTROL) ctl_ff <= wb_dat_i[9:0];
        if (wb_adr_i == OFS_PERIOD_COMPARE) per_ff <= wb_dat_i[15:0];
        if (wb_adr_i == OFS_DUTY_COMPARE) duty_ff <= wb_dat_i[15:0];
      end else if ($rose(pwm_out) && rises_ff != 2'h2) begin
        rises_ff <= rises_ff + 2'h1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_reset_quiet: assert property (
    $rose(rst_n) |-> (!pwm_out && !wb_ack_o && wb_dat_o == RD_ZERO))
    else $error("outputs busy after reset");
  a_stop_frozen: assert property (
    (ctl_ff[5:4] == MODE_STOP && !wb_cyc_i && !$past(wb_cyc_i)) |=> $stable(pwm_out))
    else $error("pin moved while stopped");
  a_up_period: assert property (
    ($rose(pwm_out) && sys_up) |-> gap_ff == ({1'b0, per_ff} + 17'h0_0001) << ctl_ff[7:6])
    else $error("up-mode period wrong");
  a_duty_high: assert property (
    ($fell(pwm_out) && sys_up) |-> gap_ff == ({1'b0, duty_ff} + 17'h0_0001) << ctl_ff[7:6])
    else $error("high time wrong");
  a_updown_span: assert property (
    ($rose(pwm_out) && rises_ff == 2'h2 && ctl_ff[9:4] == 6'h33) |-> gap_ff == {per_ff, 1'b0})
    else $error("up-down period wrong");
endmodule

bind pwm_dac_timer pwm_dac_timer_assert u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_tick_pin(ext_tick_pin),
  .aux_tick_pin(aux_tick_pin), .subsystem_clock_tick(subsystem_clock_tick),
  .pwm_out(pwm_out)
);

/* File: sim/rc_filter_model.sv */
`timescale 1ns/100ps

// ---------------------------------------------------------------
// rc low-pass filter on the pwm pin
// ---------------------------------------------------------------
module rc_filter_model #(
  parameter real TAU = 200.0
) (
  input wire logic sys_clk,
  input wire logic pwm_in,
  output real      level
);
  initial level = 0.0;

  // first-order step per clock toward the pin level
  always @(posedge sys_clk) begin
    level <= level + ((pwm_in === 1'b1 ? 1.0 : 0.0) - level) / TAU;
  end
endmodule

/* File: sim/up_mode_pwm_dac_timer_test.sv */
`timescale 1ns/100ps

module up_mode_pwm_dac_timer_test;
  import pwm_dac_pkg::*;

  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        sub_tick = 1'b0;
  logic        ext_pin = 1'b0;
  logic        aux_pin = 1'b0;
  logic        pwm;
  real         level;
  int          n_fail = 0;
  int          n_checks = 0;
  int          ph = 0;
  int          hi;
  int          per;
  int          d;
  time         t0;
  logic [3:0]  offs [5] = '{OFS_COUNTER_CONTROL, OFS_PERIOD_COMPARE, OFS_DUTY_CONTROL,
                            OFS_DUTY_COMPARE, 4'h1};
  logic [1:0]  srcs [7] = '{SRC_SYS_CLK, SRC_SYS_CLK, SRC_SYS_CLK, SRC_SYS_CLK,
                            SRC_SUBSYSTEM, SRC_EXT_TICK, SRC_AUX_TICK};
  int          mult [7] = '{1, 2, 4, 8, 5, 6, 14};

  pwm_dac_timer DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_tick_pin(ext_pin), .aux_tick_pin(aux_pin), .subsystem_clock_tick(sub_tick),
    .pwm_out(pwm)
  );

  rc_filter_model FLT (.sys_clk(sys_clk), .pwm_in(pwm), .level(level));

  // ---------------------------------------------------------------
  // clock, tick sources and helpers
  // ---------------------------------------------------------------
  always #5 sys_clk = ~sys_clk;

  // subsystem tick every 5, ext pin period 6, aux pin period 14
  always @(posedge sys_clk) begin
    ph <= ph + 1;
    sub_tick <= (ph % 5 == 0);
    ext_pin <= ((ph / 3) % 2 == 1);
    aux_pin <= ((ph / 7) % 2 == 1);
  end

  function automatic int exp_len(input int n, input int m);
    return (n + 1) * m;
  endfunction

  function automatic bit lvl_ok(input real v, input int dd, input int p);
    real e;
    e = real'(exp_len(dd, 1)) / real'(exp_len(p, 1));
    return (v - e < 0.06) && (e - v < 0.06);
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] dat,
                    input logic [3:0] s);
    int n;
    @(posedge sys_clk);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= dat;
    sel <= s;
    n = 0;
    do @(posedge sys_clk); while (ack !== 1'b1 && n++ < 20);
    rd = rdat;
    req <= 1'b0;
    if (n >= 20) chk("ack", 32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic wrt(input logic [3:0] a, input logic [31:0] dat);
    wb(1'b1, a, dat, 4'hf);
  endtask

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000, 4'hf);
    chk("register", rd, exp);
  endtask

  task automatic setup(input logic [1:0] src, input logic [1:0] dv, input logic [1:0] md,
                       input int p, input int dd, input logic lld);
    wrt(OFS_DUTY_CONTROL, (32'(lld) << DC_LLD_BIT) | (32'(OMOD_RESET_SET) << DC_OMOD_LSB));
    wrt(OFS_DUTY_COMPARE, 32'(dd));
    wrt(OFS_PERIOD_COMPARE, 32'(p));
    wrt(OFS_COUNTER_CONTROL, (32'(src) << CC_SRC_LSB) | (32'(dv) << CC_DIV_LSB)
        | (32'(md) << CC_MODE_LSB) | (32'h0000_0001 << CC_CLR_BIT));
  endtask

  // high time and period of the third full pin cycle
  task automatic meas(output int h, output int p);
    int  n;
    time ts;
    n = 0;
    repeat (2) begin
      while (pwm !== 1'b0 && n++ < 40000) @(posedge sys_clk);
      while (pwm !== 1'b1 && n++ < 40000) @(posedge sys_clk);
      ts = $time;
      while (pwm === 1'b1 && n++ < 40000) @(posedge sys_clk);
      h = int'(($time - ts) / 10);
      while (pwm !== 1'b1 && n++ < 40000) @(posedge sys_clk);
      p = int'(($time - ts) / 10);
    end
  endtask

  task automatic done(input string nm);
    $display("test %s finished", nm);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // test sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(32'ha1ac_2808));
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk("pin", 32'(pwm), 32'h0000_0000);
    foreach (offs[i]) rdc(offs[i], 32'h0000_0000);
    wb(1'b1, 4'h3, 32'hffff_ffff, 4'hf);
    rdc(4'h3, 32'h0000_0000);
    wb(1'b1, OFS_PERIOD_COMPARE, 32'h0000_1234, 4'h1);
    rdc(OFS_PERIOD_COMPARE, 32'h0000_0034);
    done("registers");
    for (int i = 0; i < 7; i++) begin
      setup(srcs[i], 2'(i < 4 ? i : 0), MODE_UP, 3, 1, 1'b1);
      meas(hi, per);
      chk("period", 32'(per), 32'(exp_len(3, mult[i])));
      chk("high", 32'(hi), 32'(exp_len(1, mult[i])));
    end
    done("sources");
    setup(SRC_SYS_CLK, 2'h0, MODE_UP_DOWN, 5, 2, 1'b1);
    meas(hi, per);
    chk("updown", 32'(per), 32'(2 * 5));
    done("updown");
    for (int l = 1; l >= 0; l--) begin
      setup(SRC_SYS_CLK, 2'h0, MODE_UP, 40, 5, l[0]);
      meas(hi, per);
      t0 = $time;
      wrt(OFS_DUTY_COMPARE, 32'd25);
      while (pwm === 1'b1 && $time - t0 < 1000) @(posedge sys_clk);
      chk("load", 32'(($time - t0) / 10), 32'(exp_len(l ? 5 : 25, 1)));
    end
    done("latch_load");
    setup(SRC_SYS_CLK, 2'h0, MODE_CONTINUOUS, 10, 5, 1'b0);
    repeat (300) @(posedge sys_clk);
    t0 = $time;
    wrt(OFS_COUNTER_CONTROL, (32'(SRC_SYS_CLK) << CC_SRC_LSB) | 32'(MODE_UP) << CC_MODE_LSB);
    while (pwm === 1'b1 && $time - t0 < 2000) @(posedge sys_clk);
    chk("restart", 32'($time - t0 < 200), 32'h0000_0001);
    done("restart");
    setup(SRC_SUBSYSTEM, 2'h0, MODE_UP, 1000, 0, 1'b1);
    meas(hi, per);
    chk("period", 32'(per), 32'(exp_len(1000, 5)));
    chk("high", 32'(hi), 32'(exp_len(0, 5)));
    done("init");
    setup(SRC_SYS_CLK, 2'h0, MODE_UP, 20, 1, 1'b1);
    repeat (6) begin
      d = 1 + $urandom % 19;
      wrt(OFS_DUTY_COMPARE, 32'(d));
      repeat (1500) @(posedge sys_clk);
      meas(hi, per);
      chk("high", 32'(hi), 32'(exp_len(d, 1)));
      chk("level", 32'(lvl_ok(level, d, 20)), 32'h0000_0001);
    end
    done("random");
    rst_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk("pin", 32'(pwm), 32'h0000_0000);
    rdc(OFS_COUNTER_CONTROL, 32'h0000_0000);
    rdc(OFS_PERIOD_COMPARE, 32'h0000_0000);
    rdc(OFS_DUTY_COMPARE, 32'h0000_0000);
    repeat (40) @(posedge sys_clk);
    chk("stopped", 32'(pwm), 32'h0000_0000);
    done("reset");
    report_and_stop();
  end

  // cut short a hung run
  initial begin
    #1_000_000;
    n_fail++;
    report_and_stop();
  end
endmodule
